//--- src/pmsc_pkg.sv
/*
 Types shared by the power management status and control block.
 Assumes the register header is on the include path.
*/
package pmsc_pkg;
`include "pmsc_regs.svh"

   // Avalon-MM request from the master
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } pmsc_avm_req_t;

   // Avalon-MM answer to the master
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } pmsc_avm_rsp_t;

   // Conditioned inputs from the supply and power logic
   typedef struct packed {
      logic warn_present;
      logic ppd_wake;
   } pmsc_sense_t;

   // Control outputs toward the analog and stop-mode logic
   typedef struct packed {
      logic detect_trip_select;
      logic warn_trip_select;
      logic powerdown_enable;
      logic powerdown_kind_select;
   } pmsc_ctrl_t;

   // Bus slave phase
   typedef enum logic [0:0] {
      PMSC_IDLE,
      PMSC_ACK
   } pmsc_bus_st_t;
endpackage

//--- src/pmsc_regs.svh
/*
 Register map, field positions, reset values and bus constants of the
 power management status and control block.
 Assumes inclusion by bare name from the package and from pmsc_top.
*/
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH

// Word offset of the single register, byte address
`define PMSC_OFS_CTRL2        8'h00
`define PMSC_ADDR_W           8

// Field positions
`define PMSC_BIT_WARN_FLAG    7
`define PMSC_BIT_WARN_ACK     6
`define PMSC_BIT_DET_TRIP     5
`define PMSC_BIT_WARN_TRIP    4
`define PMSC_BIT_PPD_FLAG     3
`define PMSC_BIT_PPD_ACK      2
`define PMSC_BIT_PD_EN        1
`define PMSC_BIT_PD_KIND      0

// Reset value and read data for unmapped addresses
`define PMSC_RST_VAL          8'h00
`define PMSC_UNMAPPED_RD      32'h0000_0000

// Pin synchroniser depth
`define PMSC_SYNC_DEPTH       3

`endif

//--- src/pmsc_sync.sv
/*
 Three-stage synchroniser with agreement filter for asynchronous pins.
 Assumes the input is a level; output moves only when stages two and
 three agree, so a single-stage glitch never reaches the logic.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsc_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   // Asynchronous level in, filtered level out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] lvl_r;
   logic [WIDTH-1:0] lvl_nxt;

   // Refuse a width the chain cannot carry
   if (WIDTH < 1) begin : g_width_check
      $error("pmsc_sync: WIDTH must be at least 1");
   end

   // Stage one is read only by stage two
   assign lvl_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & lvl_r);

   // Shift chain and filtered level
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end else begin
         s1_r  <= i_async;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   assign o_level = lvl_r;
endmodule
`default_nettype wire

//--- src/pmsc_top.sv
/*
 Power management status and control register behind an Avalon-MM
 slave: sticky warning flag, partial power-down wake flag, two trip
 selects and two write-once stop-mode controls.
 Assumes the supply comparator and wake indication are asynchronous
 levels, and the power-on indication is a synchronous qualifier of reset.

*/
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pmsc_regs.svh"
module pmsc_top (
   // Clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_por,
   // Avalon-MM slave
   input  wire pmsc_pkg::pmsc_avm_req_t i_avm,
   output var  pmsc_pkg::pmsc_avm_rsp_t o_avm,
   // Sense inputs from analog and power logic
   input  wire pmsc_pkg::pmsc_sense_t  i_sense,
   // Controls toward analog and stop-mode logic
   output var  pmsc_pkg::pmsc_ctrl_t   o_ctrl
);
   import pmsc_pkg::*;

   pmsc_bus_st_t bus_st_r;
   pmsc_bus_st_t bus_st_nxt;
   pmsc_sense_t  sense_sync;
   logic [31:0]  rdata_r;
   logic [31:0]  rdata_nxt;
   logic         warn_flag_r;
   logic         warn_flag_nxt;
   logic         ppd_flag_r;
   logic         ppd_flag_nxt;
   logic         ppd_wake_d_r;
   logic         det_trip_r;
   logic         warn_trip_r;
   logic         pd_en;
   logic         pd_kind;
   logic         hit;
   logic         lane0;
   logic         wr_stb;
   logic         rd_stb;
   logic         warn_ack;
   logic         ppd_ack;
   logic         ppd_rise;
   logic [7:0]   reg_view;
   logic [7:0]   wd;

   // Condition asynchronous sense levels
   pmsc_sync #(
      .WIDTH ($bits(pmsc_sense_t))
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_sense),
      .o_level    (sense_sync)
   );

   // Decode: one access cycle is held with waitrequest, answered in the next
   assign hit    = (i_avm.address == `PMSC_OFS_CTRL2);
   assign lane0  = i_avm.byteenable[0];
   assign wd     = i_avm.writedata[7:0];
   // A write held during a non power-on reset must not reach the kept trip selects
   assign wr_stb = i_rst_n && (bus_st_r == PMSC_IDLE) && i_avm.write && hit && lane0;
   assign rd_stb = (bus_st_r == PMSC_IDLE) && i_avm.read;
   assign bus_st_nxt = (bus_st_r == PMSC_IDLE && (i_avm.read || i_avm.write)) ?
                       PMSC_ACK : PMSC_IDLE;

   // Acknowledge strobes: write-only, never stored
   assign warn_ack = wr_stb && wd[`PMSC_BIT_WARN_ACK];
   assign ppd_ack  = wr_stb && wd[`PMSC_BIT_PPD_ACK];

   // Warning flag follows a present warning; ack ignored while present
   assign warn_flag_nxt = sense_sync.warn_present ? 1'b1 :
                          (warn_ack ? 1'b0 : warn_flag_r);

   // Wake edge sets the flag and wins over a same-cycle ack
   assign ppd_rise     = sense_sync.ppd_wake && !ppd_wake_d_r;
   assign ppd_flag_nxt = ppd_rise ? 1'b1 : (ppd_ack ? 1'b0 : ppd_flag_r);

   // Register image; ack bits read 0
   assign reg_view = {warn_flag_r, 1'b0, det_trip_r, warn_trip_r,
                      ppd_flag_r, 1'b0, pd_en, pd_kind};
   assign rdata_nxt = rd_stb ? (hit ? {24'h00_0000, reg_view} : `PMSC_UNMAPPED_RD)
                             : rdata_r;

   // Bus phase and read data
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         bus_st_r <= PMSC_IDLE;
         rdata_r  <= `PMSC_UNMAPPED_RD;
      end else begin
         bus_st_r <= bus_st_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Status flags; reset clears, present warning sets again five cycles after release
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         warn_flag_r  <= 1'b0;
         ppd_flag_r   <= 1'b0;
         ppd_wake_d_r <= 1'b0;
      end else begin
         warn_flag_r  <= warn_flag_nxt;
         ppd_flag_r   <= ppd_flag_nxt;
         ppd_wake_d_r <= sense_sync.ppd_wake;
      end
   end

   // Trip selects survive all resets but power-on
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n && i_por) begin
         det_trip_r  <= 1'b0;
         warn_trip_r <= 1'b0;
      end else if (wr_stb) begin
         det_trip_r  <= wd[`PMSC_BIT_DET_TRIP];
         warn_trip_r <= wd[`PMSC_BIT_WARN_TRIP];
      end
   end

   // Write-once stop-mode controls
   pmsc_wonce u_pd_en (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_wr       (wr_stb),
      .i_wdata    (wd[`PMSC_BIT_PD_EN]),
      .o_value    (pd_en)
   );

   pmsc_wonce u_pd_kind (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_wr       (wr_stb),
      .i_wdata    (wd[`PMSC_BIT_PD_KIND]),
      .o_value    (pd_kind)
   );

   // Outputs; kind is only meaningful while power-down is enabled
   assign o_avm.readdata    = rdata_r;
   assign o_avm.waitrequest = (bus_st_r == PMSC_IDLE);
   assign o_ctrl.detect_trip_select    = det_trip_r;
   assign o_ctrl.warn_trip_select      = warn_trip_r;
   assign o_ctrl.powerdown_enable      = pd_en;
   assign o_ctrl.powerdown_kind_select = pd_kind;
endmodule
`default_nettype wire

//--- src/pmsc_wonce.sv
/*
 Write-once control bit: the first write after reset lands, later
 writes are dropped until the next reset.
 Assumes i_wr is a one-cycle strobe on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsc_wonce (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Write strobe and data
   input  wire logic i_wr,
   input  wire logic i_wdata,
   // Held value
   output logic      o_value
);
   logic val_r;
   logic done_r;

   // Lock after first write, even when the value written is 0
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         val_r  <= 1'b0;
         done_r <= 1'b0;
      end else if (i_wr && !done_r) begin
         val_r  <= i_wdata;
         done_r <= 1'b1;
      end
   end

   assign o_value = val_r;
endmodule
`default_nettype wire

//--- test/pmsc_properties.sv
/*
 Checker for the power management register block: readback of the
 controls, reset behaviour, write-once lock and the sticky warning.
 Assumes it is bound to pmsc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsc_props
   import pmsc_pkg::*;
(
   // Clock and reset
   input wire logic          i_core_clk,
   input wire logic          i_rst_n,
   input wire logic          i_por,
   // Bus and pins
   input wire pmsc_avm_req_t i_avm,
   input wire pmsc_avm_rsp_t o_avm,
   input wire pmsc_sense_t   i_sense,
   input wire pmsc_ctrl_t    o_ctrl
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // Answer phases of mapped accesses
   wire  rd_ans = !o_avm.waitrequest && i_avm.read && i_avm.address == 8'h00;
   wire  wr_ans = !o_avm.waitrequest && i_avm.write && i_avm.address == 8'h00
                  && i_avm.byteenable[0];
   logic locked_r;
   wire  locked_nxt = locked_r | wr_ans;
   logic [1:0] trip_seen_r;

   // Trip selects as last seen outside reset, compared right after release
   always_ff @(posedge i_core_clk) begin
      if (i_rst_n) begin
         trip_seen_r <= o_ctrl[3:2];
      end
   end

   // Lock seen once a write has been answered; cleared by any reset
   always_ff @(posedge i_core_clk) begin
      locked_r <= i_rst_n ? locked_nxt : 1'b0;
   end

   det_trip_a:
      assert property (rd_ans |-> o_avm.readdata[5] == o_ctrl.detect_trip_select)
      else $error("detector trip readback differs");
   warn_trip_a:
      assert property (rd_ans |-> o_avm.readdata[4] == o_ctrl.warn_trip_select)
      else $error("warning trip readback differs");
   pd_enable_a:
      assert property (rd_ans |-> o_avm.readdata[1] == o_ctrl.powerdown_enable)
      else $error("powerdown enable readback differs");
   pd_kind_a:
      assert property (rd_ans |-> o_avm.readdata[0] == o_ctrl.powerdown_kind_select)
      else $error("powerdown kind readback differs");
   por_clear_a:
      assert property ($rose(i_rst_n) && $past(i_por) |-> o_ctrl == 4'h0)
      else $error("controls not cleared by power-on reset");
   trip_keep_a:
      assert property ($rose(i_rst_n) && !$past(i_por) |->
         o_ctrl[1:0] == 2'h0 && o_ctrl[3:2] == trip_seen_r)
      else $error("other reset mishandled trip selects");
   wonce_lock_a:
      assert property (locked_r |=> $stable(o_ctrl[1:0]))
      else $error("write-once control moved after lock");
   warn_sticky_a:
      assert property (i_sense.warn_present[*8] ##1
         (i_avm.read && o_avm.waitrequest && i_avm.address == 8'h00) |=> o_avm.readdata[7])
      else $error("warning flag not set");
endmodule
bind pmsc_top pmsc_props pmsc_props_i (.i_core_clk, .i_rst_n, .i_por, .i_avm, .o_avm,
   .i_sense, .o_ctrl);
`default_nettype wire

//--- test/tb.sv
/*
 Bench for the power management register block: bus tasks and directed
 register tests with expected values.
 Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pmsc_pkg::*;
   logic          clk, rst_n, por;
   pmsc_avm_req_t req;
   pmsc_avm_rsp_t rsp;
   pmsc_sense_t   sense;
   pmsc_ctrl_t    ctrl;
   logic [7:0]    rd;
   int            n_mismatch, checks;

   pmsc_top pmsc_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_avm(req),
      .o_avm(rsp), .i_sense(sense), .o_ctrl(ctrl));

   // Clock and time-zero values
   initial begin
      {clk, rst_n, req, sense} = '0;
      por = 1'b1;
      forever #2.5 clk = ~clk;
   end

   // Verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus cycle; the request stays put until waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clk);
      req <= '{a, !w, w, be, {24'h0, d}};
      do @(posedge clk); while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata[7:0];
      req <= '0;
   endtask

   // Read and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00, 4'hF);
      chk(rd, exp);
   endtask

   // Reset, with or without the power-on qualifier
   task automatic rst(input logic p);
      @(posedge clk);
      por <= p;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      por <= 1'b0;
   endtask

   // Move the sense pins, then let the synchroniser settle
   task automatic sns(input logic w, input logic p);
      @(posedge clk);
      sense <= '{w, p};
      repeat (8) @(posedge clk);
   endtask

   // Watchdog, far beyond the fewer than 200 cycles the tests need
   initial begin
      #20us;
      n_mismatch++;
      tally_and_finish();
   end

   // Directed tests
   initial begin
      rst(1'b1);
      rchk(8'h00, 8'h00);
      rchk(8'h04, 8'h00);
      $display("reset test done");
      acc(1'b1, 8'h00, 8'h67, 4'h1);
      rchk(8'h00, 8'h23);
      chk({4'h0, ctrl}, 8'h0B);
      acc(1'b1, 8'h00, 8'h10, 4'h1);
      rchk(8'h00, 8'h13);
      chk({4'h0, ctrl}, 8'h07);
      acc(1'b1, 8'h00, 8'h00, 4'h0);
      acc(1'b1, 8'h04, 8'h00, 4'hF);
      rchk(8'h00, 8'h13);
      $display("control test done");
      rst(1'b0);
      rchk(8'h00, 8'h10);
      acc(1'b1, 8'h00, 8'h02, 4'h1);
      chk({4'h0, ctrl}, 8'h02);
      $display("soft reset test done");
      sns(1'b1, 1'b0);
      rchk(8'h00, 8'h82);
      acc(1'b1, 8'h00, 8'h40, 4'h1);
      rchk(8'h00, 8'h82);
      sns(1'b0, 1'b0);
      rchk(8'h00, 8'h82);
      acc(1'b1, 8'h00, 8'h40, 4'h1);
      rchk(8'h00, 8'h02);
      sns(1'b1, 1'b0);
      rst(1'b1);
      repeat (8) @(posedge clk);
      rchk(8'h00, 8'h80);
      sns(1'b0, 1'b1);
      rchk(8'h00, 8'h88);
      acc(1'b1, 8'h00, 8'h44, 4'h1);
      rchk(8'h00, 8'h00);
      $display("flag test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
